// file: src/pwm_mux_pkg.sv
// constants, codes and state layout for the pwm output mux and fault logic
package pwm_mux_pkg;
  localparam int NUM_ENG  = 4;
  localparam int NUM_FLT  = 4;
  localparam int NUM_DCMP = 4;
  localparam int NUM_ACMP = 7;
  localparam int NUM_EXT  = 2;
  localparam int NUM_SYNC = NUM_ACMP + NUM_EXT;
  localparam int NUM_SRC  = NUM_DCMP + NUM_SYNC;
  localparam int DUTY_W   = 16;
  localparam int CNT_W    = 8;
  localparam int WID_W    = 12;
  localparam int DCMP_W   = 12;
  localparam int SEL_W    = 4;
  localparam int ESEL_W   = 3;
  localparam int NUM_SET  = 3;

  // fault module index inside an engine
  localparam int FLT_CYC = 0;
  localparam int FLT_AB  = 1;
  localparam int FLT_A   = 2;
  localparam int FLT_B   = 3;

  // fault source vector layout
  localparam int SRC_DCMP = 0;
  localparam int SRC_ACMP = 4;
  localparam int SRC_EXT  = 11;

  // edge event index, also the low two bits of an edge source code
  localparam int EV_RISE_A = 0;
  localparam int EV_FALL_A = 1;
  localparam int EV_RISE_B = 2;
  localparam int EV_FALL_B = 3;
  localparam int ESEL_NEXT_BIT = 2;

  // output source select codes
  localparam logic [SEL_W-1:0] OSEL_OWN   = 4'h0;
  localparam logic [SEL_W-1:0] OSEL_EDGE  = 4'h1;
  localparam logic [SEL_W-1:0] OSEL_WAVE  = 4'h2;
  localparam logic [SEL_W-1:0] OSEL_CROSS = 4'h3;
  localparam logic [SEL_W-1:0] OSEL_N1A   = 4'h4;
  localparam logic [SEL_W-1:0] OSEL_N1B   = 4'h5;
  localparam logic [SEL_W-1:0] OSEL_N1C   = 4'h6;
  localparam logic [SEL_W-1:0] OSEL_N2C   = 4'h7;
  localparam logic [SEL_W-1:0] OSEL_N3C   = 4'h8;

  localparam logic [1:0] LEVELS_NONE = 2'h0;
  localparam logic [1:0] LEVELS_TWO  = 2'h2;

  typedef enum logic [1:0] {
    CFG_BASE = 2'b00,
    CFG_MID  = 2'b01,
    CFG_HIGH = 2'b10
  } cfg_set_t;

  typedef struct packed {
    cfg_set_t                        cfg;
    logic                            hires_block;
    logic                            wave_c;
    logic                            eg_a;
    logic                            eg_b;
    logic                            prev_a;
    logic                            prev_b;
    logic                            kill_a;
    logic                            kill_b;
    logic                            trunc_valid;
    logic [WID_W-1:0]                a_width;
    logic [WID_W-1:0]                b_width;
    logic [NUM_FLT-1:0]              seen;
    logic [NUM_FLT-1:0][CNT_W-1:0]   cnt;
    logic [NUM_FLT-1:0]              flag;
    logic                            out_a;
    logic                            out_b;
  } engine_t;

  typedef struct packed {
    logic [NUM_SYNC-1:0]             sync1;
    logic [NUM_SYNC-1:0]             sync2;
    engine_t [NUM_ENG-1:0]           eng;
  } state_t;

  localparam state_t STATE_RESET = '0;
endpackage

// file: src/pwm_output_mux_and_fault.sv
// four-engine output shaping: auto config sets, edge builder, output mux, fault counting and current limit
`timescale 1ns/10ps

// Operation
// - zero, one or two auto switching levels
// - filter duty picks base, mid or high set
// - four thresholds, one pair per boundary
// - hysteresis between upper and lower thresholds
// - third wave high at blank begin, low end
// - edge builder uses own and next engine
// - four edges, each own 3-bit selector
// - codes 0-3 own edges, 4-7 next engine
// - single enable; disabled builder leaves outputs alone
// - output selects live in config sets
// - output A select codes 0 to 8
// - output B select codes 0 to 8
// - neighbour engine index wraps modulo four
// - mux enabled blocks high resolution placement
// - four identical fault modules per engine
// - fault counted at most once per cycle
// - flag sets when consecutive count exceeds maximum
// - engine disable clears all four flags
// - one shared fault enable per engine
// - one per-cycle limit block per engine
// - overcurrent during A ends pulse at once
// - option: B width matches truncated A
// - any source combination routes to any input
// - digital, analog comparator and pin sources
module pwm_output_mux_and_fault
  import pwm_mux_pkg::*;
(
  input  wire logic                                                        clock_i,
  input  wire logic                                                        reset_i,
  input  wire logic                                                        clk_en_i,
  input  wire logic [pwm_mux_pkg::NUM_ENG-1:0]                             pwm_a_raw_i,
  input  wire logic [pwm_mux_pkg::NUM_ENG-1:0]                             pwm_b_raw_i,
  input  wire logic [pwm_mux_pkg::NUM_ENG-1:0]                             blank_begin_i,
  input  wire logic [pwm_mux_pkg::NUM_ENG-1:0]                             blank_end_i,
  input  wire logic [pwm_mux_pkg::NUM_ENG-1:0]                             cycle_start_i,
  input  wire logic [pwm_mux_pkg::NUM_ENG-1:0]                             engine_enable_i,
  input  wire logic [pwm_mux_pkg::NUM_ENG-1:0]                             fault_enable_i,
  input  wire logic [pwm_mux_pkg::NUM_ENG-1:0][pwm_mux_pkg::DUTY_W-1:0]    filter_duty_i,
  input  wire logic [pwm_mux_pkg::NUM_ENG-1:0][1:0]                        auto_levels_i,
  input  wire logic [pwm_mux_pkg::NUM_ENG-1:0][pwm_mux_pkg::DUTY_W-1:0]    thr_low_lower_i,
  input  wire logic [pwm_mux_pkg::NUM_ENG-1:0][pwm_mux_pkg::DUTY_W-1:0]    thr_low_upper_i,
  input  wire logic [pwm_mux_pkg::NUM_ENG-1:0][pwm_mux_pkg::DUTY_W-1:0]    thr_high_lower_i,
  input  wire logic [pwm_mux_pkg::NUM_ENG-1:0][pwm_mux_pkg::DUTY_W-1:0]    thr_high_upper_i,
  input  wire logic [pwm_mux_pkg::NUM_ENG-1:0][pwm_mux_pkg::NUM_SET-1:0]   mux_enable_i,
  input  wire logic [pwm_mux_pkg::NUM_ENG-1:0][pwm_mux_pkg::NUM_SET-1:0][pwm_mux_pkg::SEL_W-1:0] sel_a_i,
  input  wire logic [pwm_mux_pkg::NUM_ENG-1:0][pwm_mux_pkg::NUM_SET-1:0][pwm_mux_pkg::SEL_W-1:0] sel_b_i,
  input  wire logic [pwm_mux_pkg::NUM_ENG-1:0]                             edge_enable_i,
  input  wire logic [pwm_mux_pkg::NUM_ENG-1:0][3:0][pwm_mux_pkg::ESEL_W-1:0] edge_sel_i,
  input  wire logic [pwm_mux_pkg::NUM_ENG-1:0][pwm_mux_pkg::NUM_FLT-1:0][pwm_mux_pkg::CNT_W-1:0] max_count_i,
  input  wire logic [pwm_mux_pkg::NUM_ENG-1:0][pwm_mux_pkg::NUM_FLT-1:0][pwm_mux_pkg::NUM_SRC-1:0] fault_route_i,
  input  wire logic [pwm_mux_pkg::NUM_ENG-1:0]                             b_match_enable_i,
  input  wire logic [pwm_mux_pkg::NUM_DCMP-1:0][pwm_mux_pkg::DCMP_W-1:0]   dcmp_value_i,
  input  wire logic [pwm_mux_pkg::NUM_DCMP-1:0][pwm_mux_pkg::DCMP_W-1:0]   dcmp_threshold_i,
  input  wire logic [pwm_mux_pkg::NUM_ACMP-1:0]                            acmp_i,
  input  wire logic [pwm_mux_pkg::NUM_EXT-1:0]                             fault_pin_i,
  output wire logic [pwm_mux_pkg::NUM_ENG-1:0]                             pwm_out_a_o,
  output wire logic [pwm_mux_pkg::NUM_ENG-1:0]                             pwm_out_b_o,
  output wire logic [pwm_mux_pkg::NUM_ENG-1:0]                             blank_window_wave_o,
  output wire logic [pwm_mux_pkg::NUM_ENG-1:0][1:0]                        cfg_set_o,
  output wire logic [pwm_mux_pkg::NUM_ENG-1:0][pwm_mux_pkg::NUM_FLT-1:0]   fault_flag_o,
  output wire logic [pwm_mux_pkg::NUM_ENG-1:0]                             per_cycle_limit_o,
  output wire logic [pwm_mux_pkg::NUM_ENG-1:0]                             hires_allowed_o
);
  import pwm_mux_pkg::*;

  state_t                          st;
  state_t                          next_st;
  logic [NUM_ENG-1:0][NUM_FLT-1:0] det;
  logic [NUM_ENG-1:0]              trip;

  function automatic int nxt(input int e, input int k);
    return (e + k) % NUM_ENG;
  endfunction

  function automatic cfg_set_t pick_cfg(input cfg_set_t cur, input logic [1:0] lv, input logic [DUTY_W-1:0] d,
                                        input logic [DUTY_W-1:0] ll, input logic [DUTY_W-1:0] lu,
                                        input logic [DUTY_W-1:0] hl, input logic [DUTY_W-1:0] hu);
    cfg_set_t r;
    r = cur;
    if (lv == LEVELS_NONE)
    begin
      r = CFG_BASE;
    end
    else
    begin
      case (cur)
        CFG_BASE: if (d > lu) r = CFG_MID;
        CFG_MID:
        begin
          if (d < ll)
            r = CFG_BASE;
          else if (lv >= LEVELS_TWO && d > hu)
            r = CFG_HIGH;
        end
        CFG_HIGH:
        begin
          if (lv < LEVELS_TWO || d < hl)
            r = CFG_MID;
        end
        default: r = CFG_BASE;
      endcase
    end
    return r;
  endfunction

  function automatic logic edge_hit(input logic [ESEL_W-1:0] sel, input logic [3:0] own_ev,
                                    input logic [3:0] nxt_ev);
    return sel[ESEL_NEXT_BIT] ? nxt_ev[sel[1:0]] : own_ev[sel[1:0]];
  endfunction

  // p is the pass-through output, x the crossover output of the same engine
  function automatic logic pick_out(input logic [SEL_W-1:0] code, input logic p, input logic x,
                                    input logic eg, input logic c, input logic na, input logic nb,
                                    input logic c1, input logic c2, input logic c3);
    logic r;
    case (code)
      OSEL_OWN:   r = p;
      OSEL_EDGE:  r = eg;
      OSEL_WAVE:  r = c;
      OSEL_CROSS: r = x;
      OSEL_N1A:   r = na;
      OSEL_N1B:   r = nb;
      OSEL_N1C:   r = c1;
      OSEL_N2C:   r = c2;
      OSEL_N3C:   r = c3;
      default:    r = p;
    endcase
    return r;
  endfunction

  always_comb
  begin
    logic [NUM_ENG-1:0][3:0]  ev;
    logic [NUM_ENG-1:0]       a_eff;
    logic [NUM_ENG-1:0]       b_eff;
    logic [NUM_ENG-1:0]       wc;
    logic [NUM_SRC-1:0]       src;
    logic [NUM_DCMP-1:0]      dcmp_hit;
    logic                     b_stop;
    logic                     first;
    logic [CNT_W-1:0]         base_cnt;
    logic [CNT_W:0]           inc;
    logic                     eg_a;
    logic                     eg_b;
    logic                     oa;
    logic                     ob;
    cfg_set_t                 cs;
    int                       n1;
    ev       = '0;
    a_eff    = '0;
    b_eff    = '0;
    wc       = '0;
    dcmp_hit = '0;
    b_stop   = 1'b0;
    first    = 1'b0;
    base_cnt = '0;
    inc      = '0;
    eg_a     = 1'b0;
    eg_b     = 1'b0;
    oa       = 1'b0;
    ob       = 1'b0;
    cs       = CFG_BASE;
    n1       = 0;
    det      = '0;
    trip     = '0;
    next_st  = st;

    // comparator and pin lines are asynchronous, only the second stage is used
    next_st.sync1 = {fault_pin_i, acmp_i};
    next_st.sync2 = st.sync1;
    for (int d = 0; d < NUM_DCMP; d++)
    begin
      dcmp_hit[d] = dcmp_value_i[d] > dcmp_threshold_i[d];
    end
    src = {st.sync2, dcmp_hit};

    for (int e = 0; e < NUM_ENG; e++)
    begin
      ev[e][EV_RISE_A] = pwm_a_raw_i[e] & ~st.eng[e].prev_a;
      ev[e][EV_FALL_A] = ~pwm_a_raw_i[e] & st.eng[e].prev_a;
      ev[e][EV_RISE_B] = pwm_b_raw_i[e] & ~st.eng[e].prev_b;
      ev[e][EV_FALL_B] = ~pwm_b_raw_i[e] & st.eng[e].prev_b;
      wc[e] = st.eng[e].wave_c;
      for (int f = 0; f < NUM_FLT; f++)
      begin
        det[e][f] = fault_enable_i[e] & engine_enable_i[e] & (|(src & fault_route_i[e][f]));
      end
      trip[e] = pwm_a_raw_i[e] & det[e][FLT_CYC];
    end

    for (int e = 0; e < NUM_ENG; e++)
    begin
      next_st.eng[e].prev_a = pwm_a_raw_i[e];
      next_st.eng[e].prev_b = pwm_b_raw_i[e];
      next_st.eng[e].cfg = pick_cfg(st.eng[e].cfg, auto_levels_i[e], filter_duty_i[e], thr_low_lower_i[e],
                                    thr_low_upper_i[e], thr_high_lower_i[e], thr_high_upper_i[e]);
      next_st.eng[e].hires_block = mux_enable_i[e][next_st.eng[e].cfg];

      if (blank_begin_i[e])
        next_st.eng[e].wave_c = 1'b1;
      else if (blank_end_i[e])
        next_st.eng[e].wave_c = 1'b0;

      // the pulse is cut in the very cycle the comparator trips and stays cut until A rises again
      a_eff[e] = pwm_a_raw_i[e] & ~trip[e] & ~(st.eng[e].kill_a & ~ev[e][EV_RISE_A]);
      next_st.eng[e].kill_a = trip[e] | (st.eng[e].kill_a & ~ev[e][EV_RISE_A]);
      next_st.eng[e].trunc_valid = (trip[e] & pwm_a_raw_i[e]) | (st.eng[e].trunc_valid & ~ev[e][EV_RISE_A]);
      if (ev[e][EV_RISE_A])
        next_st.eng[e].a_width = {{(WID_W-1){1'b0}}, a_eff[e]};
      else if (a_eff[e])
        next_st.eng[e].a_width = st.eng[e].a_width + {{(WID_W-1){1'b0}}, 1'b1};

      b_stop = b_match_enable_i[e] & st.eng[e].trunc_valid & pwm_b_raw_i[e] & ~ev[e][EV_RISE_B]
               & (st.eng[e].b_width >= st.eng[e].a_width);
      b_eff[e] = pwm_b_raw_i[e] & ~b_stop & ~(st.eng[e].kill_b & ~ev[e][EV_RISE_B]);
      next_st.eng[e].kill_b = b_stop | (st.eng[e].kill_b & ~ev[e][EV_RISE_B]);
      if (ev[e][EV_RISE_B])
        next_st.eng[e].b_width = {{(WID_W-1){1'b0}}, 1'b1};
      else if (pwm_b_raw_i[e])
        next_st.eng[e].b_width = st.eng[e].b_width + {{(WID_W-1){1'b0}}, 1'b1};

      n1 = nxt(e, 1);
      if (!edge_enable_i[e])
      begin
        next_st.eng[e].eg_a = 1'b0;
        next_st.eng[e].eg_b = 1'b0;
      end
      else
      begin
        // a set and a clear in the same cycle leave the output high
        if (edge_hit(edge_sel_i[e][0], ev[e], ev[n1]))
          next_st.eng[e].eg_a = 1'b1;
        else if (edge_hit(edge_sel_i[e][1], ev[e], ev[n1]))
          next_st.eng[e].eg_a = 1'b0;
        if (edge_hit(edge_sel_i[e][2], ev[e], ev[n1]))
          next_st.eng[e].eg_b = 1'b1;
        else if (edge_hit(edge_sel_i[e][3], ev[e], ev[n1]))
          next_st.eng[e].eg_b = 1'b0;
      end

      for (int f = 0; f < NUM_FLT; f++)
      begin
        first = det[e][f] & (cycle_start_i[e] | ~st.eng[e].seen[f]);
        base_cnt = (cycle_start_i[e] & ~st.eng[e].seen[f]) ? '0 : st.eng[e].cnt[f];
        inc = {1'b0, base_cnt} + {{CNT_W{1'b0}}, 1'b1};
        if (!engine_enable_i[e])
        begin
          next_st.eng[e].seen[f] = 1'b0;
          next_st.eng[e].cnt[f] = '0;
          next_st.eng[e].flag[f] = 1'b0;
        end
        else
        begin
          next_st.eng[e].seen[f] = first | (st.eng[e].seen[f] & ~cycle_start_i[e]);
          // saturates so a long fault run can never wrap back under the maximum
          next_st.eng[e].cnt[f] = (first && !inc[CNT_W]) ? inc[CNT_W-1:0] : base_cnt;
          next_st.eng[e].flag[f] = st.eng[e].flag[f] | (first & (inc > {1'b0, max_count_i[e][f]}));
        end
      end
    end

    for (int e = 0; e < NUM_ENG; e++)
    begin
      cs = st.eng[e].cfg;
      eg_a = edge_enable_i[e] ? st.eng[e].eg_a : a_eff[e];
      eg_b = edge_enable_i[e] ? st.eng[e].eg_b : b_eff[e];
      n1 = nxt(e, 1);
      oa = a_eff[e];
      ob = b_eff[e];
      if (mux_enable_i[e][cs])
      begin
        oa = pick_out(sel_a_i[e][cs], a_eff[e], b_eff[e], eg_a, wc[e], a_eff[n1], b_eff[n1],
                      wc[n1], wc[nxt(e, 2)], wc[nxt(e, 3)]);
        ob = pick_out(sel_b_i[e][cs], b_eff[e], a_eff[e], eg_b, wc[e], a_eff[n1], b_eff[n1],
                      wc[n1], wc[nxt(e, 2)], wc[nxt(e, 3)]);
      end
      next_st.eng[e].out_a = oa & engine_enable_i[e]
                             & ~(st.eng[e].flag[FLT_CYC] | st.eng[e].flag[FLT_AB] | st.eng[e].flag[FLT_A]);
      next_st.eng[e].out_b = ob & engine_enable_i[e]
                             & ~(st.eng[e].flag[FLT_CYC] | st.eng[e].flag[FLT_AB] | st.eng[e].flag[FLT_B]);
    end
  end

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      st <= STATE_RESET;
    else if (clk_en_i)
      st <= next_st;
  end

  for (genvar g = 0; g < NUM_ENG; g++)
  begin : g_out
    assign pwm_out_a_o[g]         = st.eng[g].out_a;
    assign pwm_out_b_o[g]         = st.eng[g].out_b;
    assign blank_window_wave_o[g] = st.eng[g].wave_c;
    assign cfg_set_o[g]           = st.eng[g].cfg;
    assign fault_flag_o[g]        = st.eng[g].flag;
    assign per_cycle_limit_o[g]   = st.eng[g].kill_a;
    assign hires_allowed_o[g]     = ~st.eng[g].hires_block;
  end

  property p_no_levels;
    @(posedge clock_i) disable iff (reset_i)
    (clk_en_i && auto_levels_i[2] == LEVELS_NONE) |=> (cfg_set_o[2] == CFG_BASE);
  endproperty
  a_no_levels: assert property (p_no_levels) else $error("auto switching off but set not base");
  property p_go_mid;
    @(posedge clock_i) disable iff (reset_i)
    (clk_en_i && st.eng[2].cfg == CFG_BASE && auto_levels_i[2] != LEVELS_NONE
     && filter_duty_i[2] > thr_low_upper_i[2]) |=> (cfg_set_o[2] == CFG_MID);
  endproperty
  a_go_mid: assert property (p_go_mid) else $error("duty above low upper did not select mid");
  property p_hold_mid;
    @(posedge clock_i) disable iff (reset_i)
    (clk_en_i && st.eng[2].cfg == CFG_MID && auto_levels_i[2] != LEVELS_NONE
     && filter_duty_i[2] >= thr_low_lower_i[2] && filter_duty_i[2] <= thr_high_upper_i[2])
    |=> (cfg_set_o[2] == CFG_MID);
  endproperty
  a_hold_mid: assert property (p_hold_mid) else $error("mid set left inside hysteresis band");
  property p_wave_high;
    @(posedge clock_i) disable iff (reset_i)
    (clk_en_i && blank_begin_i[0]) |=> blank_window_wave_o[0];
  endproperty
  a_wave_high: assert property (p_wave_high) else $error("third wave not high after blank begin");
  property p_wave_low;
    @(posedge clock_i) disable iff (reset_i)
    (clk_en_i && blank_end_i[0] && !blank_begin_i[0]) |=> !blank_window_wave_o[0];
  endproperty
  a_wave_low: assert property (p_wave_low) else $error("third wave not low after blank end");
  property p_edge_off;
    @(posedge clock_i) disable iff (reset_i)
    (clk_en_i && !edge_enable_i[0]) |=> (!st.eng[0].eg_a && !st.eng[0].eg_b);
  endproperty
  a_edge_off: assert property (p_edge_off) else $error("edge builder active while disabled");
  property p_flag_clear;
    @(posedge clock_i) disable iff (reset_i)
    (clk_en_i && !engine_enable_i[1]) |=> (fault_flag_o[1] == '0);
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("fault flags not cleared by engine disable");
  property p_flag_sticky;
    @(posedge clock_i) disable iff (reset_i)
    (clk_en_i && fault_flag_o[1][FLT_A] && engine_enable_i[1]) |=> fault_flag_o[1][FLT_A];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("fault flag dropped while enabled");
  property p_once_per_cycle;
    @(posedge clock_i) disable iff (reset_i)
    (clk_en_i && engine_enable_i[1] && st.eng[1].seen[FLT_AB] && !cycle_start_i[1])
    |=> $stable(st.eng[1].cnt[FLT_AB]);
  endproperty
  a_once_per_cycle: assert property (p_once_per_cycle) else $error("fault counted twice in one cycle");
  property p_count_reset;
    @(posedge clock_i) disable iff (reset_i)
    (clk_en_i && engine_enable_i[0] && cycle_start_i[0] && !st.eng[0].seen[FLT_B] && !det[0][FLT_B])
    |=> (st.eng[0].cnt[FLT_B] == '0);
  endproperty
  a_count_reset: assert property (p_count_reset) else $error("counter kept after fault-free cycle");
  property p_limit_cut;
    @(posedge clock_i) disable iff (reset_i)
    (clk_en_i && trip[0] && (!mux_enable_i[0][st.eng[0].cfg] || sel_a_i[0][st.eng[0].cfg] == OSEL_OWN))
    |=> (!pwm_out_a_o[0] && per_cycle_limit_o[0]);
  endproperty
  a_limit_cut: assert property (p_limit_cut) else $error("current limit did not end output A");
endmodule

// file: dv/pwm_stage_model.sv
// stand-in for the switching stage: raw waveforms, cycle and blanking events, current comparator
`timescale 1ns/10ps
module pwm_stage_model
  import pwm_mux_pkg::*;
(
  input  wire logic                             clock_i,
  input  wire logic                             reset_i,
  input  wire logic                             overcurrent_i,
  output wire logic [pwm_mux_pkg::NUM_ENG-1:0]  raw_a_o,
  output wire logic [pwm_mux_pkg::NUM_ENG-1:0]  raw_b_o,
  output wire logic [pwm_mux_pkg::NUM_ENG-1:0]  blank_begin_o,
  output wire logic [pwm_mux_pkg::NUM_ENG-1:0]  blank_end_o,
  output wire logic [pwm_mux_pkg::NUM_ENG-1:0]  cycle_start_o,
  output wire logic [pwm_mux_pkg::NUM_ACMP-1:0] acmp_o
);
  logic [2:0] phase;

  // eight-cycle switching period, all engines in step
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      phase <= 3'h0;
    else
      phase <= phase + 3'h1;
  end

  assign cycle_start_o = {NUM_ENG{phase == 3'h0}};
  assign raw_a_o       = {NUM_ENG{(phase >= 3'h1) && (phase <= 3'h4)}};
  assign raw_b_o       = {NUM_ENG{phase >= 3'h6}};
  assign blank_begin_o = {NUM_ENG{phase == 3'h1}};
  assign blank_end_o   = {NUM_ENG{phase == 3'h3}};
  // current is already high as A starts, so after the two sync stages the cut leaves one cycle of A
  assign acmp_o = NUM_ACMP'(overcurrent_i && (phase <= 3'h4));
endmodule

// file: dv/pwm_output_mux_and_fault_tb_top.sv
// self-checking bench: output mux, auto config sets, fault counting and current limit
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin errors++; \
  $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module pwm_output_mux_and_fault_tb_top;
  import pwm_mux_pkg::*;
  logic clock_i = 1'b0, reset_i = 1'b1, oc = 1'b0, use_st = 1'b1;
  logic [NUM_ENG-1:0] st_a = '0, st_b = '0, st_bb = '0, st_be = '0, en = '0, fen = '0, eg_en = '0, bm = '0;
  logic [NUM_ENG-1:0][3:0][ESEL_W-1:0] esel = '0;
  logic [NUM_EXT-1:0] pin = '0;
  logic [NUM_ENG-1:0] m_a, m_b, m_bb, m_be, m_cs, out_a, out_b, wave, pcl, hires;
  logic [NUM_ENG-1:0][DUTY_W-1:0] duty = '0, tll = {4{16'h0064}}, tlu = {4{16'h00c8}};
  logic [NUM_ENG-1:0][DUTY_W-1:0] thl = {4{16'h012c}}, thu = {4{16'h0190}};
  logic [NUM_ENG-1:0][1:0] lev = '0, cfg;
  logic [NUM_ENG-1:0][NUM_SET-1:0] mux_en = '0;
  logic [NUM_ENG-1:0][NUM_SET-1:0][SEL_W-1:0] sa = '0, sb = '0;
  logic [NUM_ENG-1:0][NUM_FLT-1:0][CNT_W-1:0] maxc = '1;
  logic [NUM_ENG-1:0][NUM_FLT-1:0][NUM_SRC-1:0] route = '0;
  logic [NUM_ENG-1:0][NUM_FLT-1:0] flag;
  logic [NUM_DCMP-1:0][DCMP_W-1:0] dval = '0, dthr = {4{12'h100}};
  logic [NUM_ACMP-1:0] m_ac;
  logic [DUTY_W-1:0] dseq [8] = '{16'h0096, 16'h00fa, 16'h0096, 16'h0032, 16'h00fa, 16'h01c2, 16'h015e, 16'h00fa};
  logic [1:0] eset [8] = '{2'h0, 2'h1, 2'h1, 2'h0, 2'h1, 2'h2, 2'h2, 2'h1};
  int errors = 0;
  int samples_checked = 0;

  pwm_stage_model pwm_stage_model_i (.clock_i, .reset_i, .overcurrent_i(oc), .raw_a_o(m_a), .raw_b_o(m_b),
    .blank_begin_o(m_bb), .blank_end_o(m_be), .cycle_start_o(m_cs), .acmp_o(m_ac));

  pwm_output_mux_and_fault pwm_output_mux_and_fault_i (.clock_i, .reset_i, .clk_en_i(1'b1),
    .pwm_a_raw_i(use_st ? st_a : m_a), .pwm_b_raw_i(use_st ? st_b : m_b),
    .blank_begin_i(use_st ? st_bb : m_bb), .blank_end_i(use_st ? st_be : m_be),
    .cycle_start_i(use_st ? 4'h0 : m_cs), .engine_enable_i(en), .fault_enable_i(fen), .filter_duty_i(duty),
    .auto_levels_i(lev), .thr_low_lower_i(tll), .thr_low_upper_i(tlu), .thr_high_lower_i(thl),
    .thr_high_upper_i(thu), .mux_enable_i(mux_en), .sel_a_i(sa), .sel_b_i(sb), .edge_enable_i(eg_en),
    .edge_sel_i(esel), .max_count_i(maxc), .fault_route_i(route), .b_match_enable_i(bm),
    .dcmp_value_i(dval), .dcmp_threshold_i(dthr), .acmp_i(m_ac), .fault_pin_i(pin),
    .pwm_out_a_o(out_a), .pwm_out_b_o(out_b), .blank_window_wave_o(wave), .cfg_set_o(cfg),
    .fault_flag_o(flag), .per_cycle_limit_o(pcl), .hires_allowed_o(hires));

  initial
  begin
    forever #12.5 clock_i = ~clock_i;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask

  // park mid-way through a switching period so counts never straddle a cycle start
  task automatic sync_mid;
    for (int i = 0; i < 9 && m_cs[1] !== 1'b1; i++) cyc(1);
    cyc(4);
  endtask

  function automatic logic mux_exp(input int code, input int e, input logic isb, input logic [3:0] a, b, c);
    int n1 = (e + 1) % NUM_ENG;
    case (code)
      0, 1: return isb ? b[e] : a[e];
      2: return c[e];
      3: return isb ? a[e] : b[e];
      4: return a[n1];
      5: return b[n1];
      default: return c[(e + code - 5) % NUM_ENG];
    endcase
  endfunction

  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    logic [3:0] w;
    logic hit;
    int m;
    void'($urandom(21341));
    cyc(16);
    reset_i = 1'b0;
    `CHK("hires_reset", 4'hf, hires)
    `CHK("cfg_reset", 8'h00, cfg)
    en = 4'hf;
    mux_en = {4{3'b001}};
    mux_en[2] = 3'b010;
    w = 4'($urandom);
    st_bb = w;
    st_be = ~w;
    cyc(1);
    st_bb = 4'h0;
    st_be = 4'h0;
    cyc(2);
    `CHK("wave", w, wave)
    for (int k = 0; k < 36; k++)
    begin
      st_a = 4'($urandom);
      st_b = 4'($urandom);
      for (int e = 0; e < NUM_ENG; e++) sa[e][0] = SEL_W'(k % 9);
      for (int e = 0; e < NUM_ENG; e++) sb[e][0] = SEL_W'((k + 4) % 9);
      cyc(3);
      for (int e = 0; e < NUM_ENG; e += 3)
      begin
        `CHK("mux_a", mux_exp(k % 9, e, 1'b0, st_a, st_b, w), out_a[e])
        `CHK("mux_b", mux_exp((k + 4) % 9, e, 1'b1, st_a, st_b, w), out_b[e])
      end
    end
    // engine 3 builds both outputs from edges of engine 0 (wrap) and clears them on its own falls
    sa[3][0] = OSEL_EDGE;
    sb[3][0] = OSEL_EDGE;
    esel[3] = {3'h3, 3'h6, 3'h1, 3'h4};
    eg_en = 4'h8;
    st_a = '0;
    st_b = '0;
    cyc(3);
    st_a = 4'h1;
    st_b = 4'h1;
    cyc(3);
    `CHK("edge_set", 2'h3, {out_a[3], out_b[3]})
    st_a = 4'h9;
    cyc(2);
    st_a = 4'h1;
    cyc(3);
    `CHK("edge_clr", 2'h1, {out_a[3], out_b[3]})
    eg_en = 4'h0;
    cyc(3);
    `CHK("edge_off", 2'h0, {out_a[3], out_b[3]})
    $display("test output mux done");
    lev[2] = 2'h2;
    for (int i = 0; i < 8; i++)
    begin
      duty[2] = dseq[i];
      cyc(3);
      `CHK("cfg_set", eset[i], cfg[2])
      `CHK("hires", eset[i] != 2'h1, hires[2])
    end
    lev[2] = 2'h0;
    cyc(3);
    `CHK("cfg_off", 2'h0, cfg[2])
    $display("test auto switching done");
    sa = '0;
    sb = '0;
    use_st = 1'b0;
    route[0][FLT_CYC] = NUM_SRC'(1) << SRC_ACMP;
    route[1][FLT_AB] = NUM_SRC'(1) << SRC_DCMP;
    fen = 4'h3;
    bm = 4'h1;
    oc = 1'b1;
    for (int i = 0; i < 24 && pcl[0] !== 1'b1; i++) cyc(1);
    `CHK("limit", 1'b1, pcl[0])
    `CHK("cut_a", 1'b0, out_a[0])
    // skip to a period that saw current from its start: A keeps one cycle, so B must too
    cyc(8);
    w = 4'h0;
    repeat (8)
    begin
      cyc(1);
      w = w + 4'(out_b[0]);
    end
    `CHK("b_match", 4'h1, w)
    oc = 1'b0;
    $display("test current limit done");
    m = 1 + $urandom % 3;
    maxc[1][FLT_AB] = CNT_W'(m);
    sync_mid();
    dval[0] = 12'h800;
    cyc(8 * m - 6);
    `CHK("flag_early", 1'b0, flag[1][FLT_AB])
    cyc(8);
    `CHK("flag_set", 1'b1, flag[1][FLT_AB])
    hit = 1'b0;
    repeat (8)
    begin
      cyc(1);
      hit |= out_a[1];
    end
    `CHK("flag_gates_a", 1'b0, hit)
    dval[0] = 12'h000;
    en[1] = 1'b0;
    cyc(2);
    en[1] = 1'b1;
    cyc(1);
    `CHK("flag_clear", 4'h0, flag[1])
    maxc[1][FLT_AB] = 8'h01;
    sync_mid();
    dval[0] = 12'h800;
    cyc(1);
    dval[0] = 12'h000;
    cyc(15);
    dval[0] = 12'h800;
    cyc(1);
    dval[0] = 12'h000;
    cyc(4);
    `CHK("gap_restart", 1'b0, flag[1][FLT_AB])
    fen[1] = 1'b0;
    dval[0] = 12'h800;
    cyc(40);
    `CHK("shared_enable", 4'h0, flag[1])
    dval[0] = 12'h000;
    fen[1] = 1'b1;
    maxc[1][FLT_A] = 8'h00;
    route[1][FLT_A] = NUM_SRC'(3) << SRC_EXT;
    pin = 2'h2;
    cyc(4);
    `CHK("pin_fault", 4'h4, flag[1])
    $display("test fault modules done");
    finish_test();
  end

  // whole run needs well under a thousand cycles
  initial
  begin
    #(25 * 3000);
    errors++;
    finish_test();
  end
endmodule
